// *** smp_pkg.sv ***
// Shared constants, types and helpers for the message parser
// Notes on behaviour
// - Newline 0x0a ends a message
// - Character with end-of-line flag also terminates
// - Four-letter-or-less keywords: short equals long
// - Longer keywords: four letters, three if vowel
// - Other truncations of a root keyword are errors
// - Keyword holds whole short or long form
// - Keyword matching ignores letter case
// - Colon between keywords descends one level
// - Question mark after last keyword makes query
// - Data only follows the final keyword
// - A space separates keyword from data
// - Semicolons split message into units
// - Leading colon returns tree position to root
// - Terminator returns tree position to root
// - Unit after semicolon resolves at previous level
// - Voltage, current, function accepted at root
// - Root offers only the listed subsystems
// - Leading asterisk marks a common command
package smp_pkg;

  localparam logic [7:0] SMP_CH_NL    = 8'h0a;
  localparam logic [7:0] SMP_CH_SPACE = 8'h20;
  localparam logic [7:0] SMP_CH_STAR  = 8'h2a;
  localparam logic [7:0] SMP_CH_COLON = 8'h3a;
  localparam logic [7:0] SMP_CH_SEMI  = 8'h3b;
  localparam logic [7:0] SMP_CH_QUERY = 8'h3f;

  localparam int         SMP_KW_MAX   = 12;
  localparam logic [3:0] SMP_KW_MAX_L = 4'hc;
  localparam int         SMP_WORD_MAX = 9;
  localparam int         SMP_ROOT_N   = 14;
  localparam logic [2:0] SMP_LVL_MAX  = 3'h7;
  localparam logic [3:0] SMP_CODE_SUB = 4'hf;
  localparam int         SMP_EV_W     = 19;

  typedef enum logic [2:0] {
    EV_KW       = 3'h0,
    EV_SET      = 3'h1,
    EV_QUERY    = 3'h2,
    EV_DATA     = 3'h3,
    EV_COMMON   = 3'h4,
    EV_UNIT_END = 3'h5,
    EV_MSG_END  = 3'h6,
    EV_ERROR    = 3'h7
  } smp_ev_e;

  typedef enum logic [2:0] {
    S_START   = 3'h0,
    S_SEP     = 3'h1,
    S_KW      = 3'h2,
    S_QRY     = 3'h3,
    S_DATA    = 3'h4,
    S_COMMON  = 3'h5,
    S_DISCARD = 3'h6
  } smp_state_e;

  function automatic logic smp_is_alpha(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
  endfunction : smp_is_alpha

  function automatic logic smp_is_alnum(input logic [7:0] c);
    return smp_is_alpha(c) || (c >= 8'h30 && c <= 8'h39);
  endfunction : smp_is_alnum

  function automatic logic [7:0] smp_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction : smp_upper

  // Long forms of root keywords, SOURCE children folded in
  function automatic logic [71:0] smp_root_word(input int e);
    case (e)
      0:       return 72'("ABORT");
      1:       return 72'("CALIBRATE");
      2:       return 72'("DISPLAY");
      3:       return 72'("INITIATE");
      4:       return 72'("LIST");
      5:       return 72'("MEASURE");
      6:       return 72'("OUTPUT");
      7:       return 72'("SOURCE");
      8:       return 72'("STATUS");
      9:       return 72'("SYSTEM");
      10:      return 72'("TRIGGER");
      11:      return 72'("VOLTAGE");
      12:      return 72'("CURRENT");
      default: return 72'("FUNCTION");
    endcase
  endfunction : smp_root_word

  function automatic logic [3:0] smp_root_len(input int e);
    case (e)
      0:       return 4'h5;
      1:       return 4'h9;
      2:       return 4'h7;
      3:       return 4'h8;
      4:       return 4'h4;
      5:       return 4'h7;
      6:       return 4'h6;
      7:       return 4'h6;
      8:       return 4'h6;
      9:       return 4'h6;
      10:      return 4'h7;
      11:      return 4'h7;
      12:      return 4'h7;
      default: return 4'h8;
    endcase
  endfunction : smp_root_len

endpackage : smp_pkg

// *** smp_skid.sv ***
// Two-entry skid buffer between parser and event consumer
`timescale 1ns/1ps
module smp_skid
#(
  parameter int W = 19
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output      logic         in_ready,
  output      logic [W-1:0] out_data,
  output      logic         out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] skid;
  logic         skid_valid;
  logic [W-1:0] next_out_data;
  logic         next_out_valid;
  logic [W-1:0] next_skid;
  logic         next_skid_valid;

  // Ready depends only on a flop, so no path from out_ready to in_ready
  assign in_ready = !skid_valid;

  always_comb
  begin
    next_out_data   = out_data;
    next_out_valid  = out_valid;
    next_skid       = skid;
    next_skid_valid = skid_valid;
    if (skid_valid)
    begin
      if (out_ready)
      begin
        next_out_data   = skid;
        next_skid_valid = 1'b0;
      end
    end
    else if (in_valid && out_valid && !out_ready)
    begin
      next_skid       = in_data;
      next_skid_valid = 1'b1;
    end
    else if (in_valid)
    begin
      next_out_data  = in_data;
      next_out_valid = 1'b1;
    end
    else if (out_ready)
    begin
      next_out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_data   <= '0;
      out_valid  <= 1'b0;
      skid       <= '0;
      skid_valid <= 1'b0;
    end
    else
    begin
      out_data   <= next_out_data;
      out_valid  <= next_out_valid;
      skid       <= next_skid;
      skid_valid <= next_skid_valid;
    end
  end

endmodule : smp_skid

// *** smp_kw_match.sv ***
// Root keyword matcher, short or long form, case already folded
`timescale 1ns/1ps
module smp_kw_match
(
  input  wire logic [95:0] buf_chars,
  input  wire logic [3:0]  buf_len,
  output      logic        hit,
  output      logic [3:0]  id
);
  import smp_pkg::*;

  always_comb
  begin
    logic [71:0] word;
    logic [3:0]  ll;
    logic [3:0]  sl;
    logic        ok;
    word = '0;
    ll   = '0;
    sl   = '0;
    ok   = 1'b0;
    hit  = 1'b0;
    id   = SMP_CODE_SUB;
    for (int e = 0; e < SMP_ROOT_N; e++)
    begin
      word = smp_root_word(e);
      ll   = smp_root_len(e);
      sl   = ll;
      if (ll > 4'h4)
      begin
        case (word[8*(ll-4) +: 8])
          8'h41, 8'h45, 8'h49, 8'h4f, 8'h55: sl = 4'h3;
          default:                           sl = 4'h4;
        endcase
      end
      // Exact short or long length only; partial spellings fail
      ok = (buf_len == sl) || (buf_len == ll);
      for (int i = 0; i < SMP_WORD_MAX; i++)
      begin
        if (i < int'(buf_len) && i < int'(ll))
        begin
          if (buf_chars[8*i +: 8] != word[8*(int'(ll)-1-i) +: 8])
          begin
            ok = 1'b0;
          end
        end
      end
      if (ok && !hit)
      begin
        hit = 1'b1;
        id  = 4'(e);
      end
    end
  end

endmodule : smp_kw_match

// *** smp_parser.sv ***
// Character-level program message parser with event output stream
`timescale 1ns/1ps
module smp_parser
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_eol,
  input  wire logic                  rx_valid,
  output      logic                  rx_ready,
  output      logic                  ev_valid,
  input  wire logic                  ev_ready,
  output      smp_pkg::smp_ev_e      ev_kind,
  output      logic [2:0]            ev_level,
  output      logic [3:0]            ev_code,
  output      logic [7:0]            ev_char,
  output      logic                  ev_end,
  output      logic                  cmd_error
);
  import smp_pkg::*;

  smp_state_e   state;
  smp_state_e   next_state;
  logic [2:0]   level;
  logic [2:0]   next_level;
  logic [2:0]   unit_level;
  logic [2:0]   next_unit_level;
  logic [95:0]  kw_buf;
  logic [95:0]  next_kw_buf;
  logic [3:0]   kw_len;
  logic [3:0]   next_kw_len;
  logic         next_cmd_error;

  logic         acc;
  logic         term;
  logic [7:0]   uch;
  logic         kw_step;
  logic         app;
  logic [95:0]  m_buf;
  logic [3:0]   m_len;
  logic         m_hit;
  logic [3:0]   m_id;
  logic         kw_ok;
  logic [3:0]   kw_code;

  logic         push;
  smp_ev_e      p_kind;
  logic [3:0]   p_code;
  logic [7:0]   p_char;
  logic         p_end;
  logic [SMP_EV_W-1:0] p_word;
  logic [SMP_EV_W-1:0] o_word;
  logic         in_ready;

  assign acc      = rx_valid && in_ready;
  assign term     = (rx_data == SMP_CH_NL) || rx_eol;
  assign uch      = smp_upper(rx_data);
  assign kw_step  = (state == S_KW) ||
                    ((state == S_START || state == S_SEP) && smp_is_alpha(rx_data));
  assign app      = kw_step && smp_is_alnum(rx_data) && (kw_len < SMP_KW_MAX_L);

  // Matcher sees the current letter too, so a letter carrying EOL resolves
  always_comb
  begin
    m_buf = kw_buf;
    m_len = kw_len;
    if (app)
    begin
      m_buf[8*kw_len +: 8] = uch;
      m_len = kw_len + 4'h1;
    end
  end

  smp_kw_match u_match
  (
    .buf_chars (m_buf),
    .buf_len   (m_len),
    .hit       (m_hit),
    .id        (m_id)
  );

  // Below root the tree is not held here; any well-formed word passes
  assign kw_ok   = (level == 3'h0) ? m_hit : (m_len != 4'h0);
  assign kw_code = (level == 3'h0) ? m_id : SMP_CODE_SUB;

  always_comb
  begin
    next_state      = state;
    next_level      = level;
    next_unit_level = unit_level;
    next_kw_buf     = kw_buf;
    next_kw_len     = kw_len;
    next_cmd_error  = 1'b0;
    push            = 1'b0;
    p_kind          = EV_DATA;
    p_code          = kw_code;
    p_char          = rx_data;
    p_end           = term;
    if (acc)
    begin
      if (kw_step && smp_is_alnum(rx_data) && !rx_eol)
      begin
        next_state  = S_KW;
        next_kw_buf = m_buf;
        next_kw_len = m_len;
        if (!app)
        begin
          // Overlong word; clear length so the next message starts clean
          next_kw_len = 4'h0;
          push        = 1'b1;
          p_kind      = EV_ERROR;
          next_state  = S_DISCARD;
          next_cmd_error = 1'b1;
        end
      end
      else if (kw_step)
      begin
        next_kw_len = 4'h0;
        push        = 1'b1;
        p_kind      = EV_SET;
        if (!kw_ok)
        begin
          p_kind = EV_ERROR;
        end
        else if (term)
        begin
          next_state = S_START;
          next_level = 3'h0;
          next_unit_level = 3'h0;
        end
        else if (rx_data == SMP_CH_COLON)
        begin
          p_kind = EV_KW;
          next_state = S_SEP;
          next_level = level + 3'h1;
          if (level == SMP_LVL_MAX)
          begin
            p_kind = EV_ERROR;
          end
        end
        else if (rx_data == SMP_CH_QUERY)
        begin
          p_kind = EV_QUERY;
          next_state = S_QRY;
          next_unit_level = level;
        end
        else if (rx_data == SMP_CH_SPACE)
        begin
          next_state = S_DATA;
          next_unit_level = level;
        end
        else if (rx_data == SMP_CH_SEMI)
        begin
          next_state = S_START;
          next_unit_level = level;
        end
        else
        begin
          p_kind = EV_ERROR;
        end
        if (p_kind == EV_ERROR)
        begin
          next_cmd_error = 1'b1;
          next_state = term ? S_START : S_DISCARD;
          next_level = term ? 3'h0 : level;
        end
      end
      else
      begin
        case (state)
          S_START:
          begin
            if (term)
            begin
              push       = 1'b1;
              p_kind     = EV_MSG_END;
              next_level = 3'h0;
              next_unit_level = 3'h0;
            end
            else if (rx_data == SMP_CH_COLON)
            begin
              next_state = S_SEP;
              next_level = 3'h0;
              next_unit_level = 3'h0;
            end
            else if (rx_data == SMP_CH_STAR)
            begin
              push       = 1'b1;
              p_kind     = EV_COMMON;
              next_state = S_COMMON;
            end
            else if (rx_data != SMP_CH_SPACE)
            begin
              push       = 1'b1;
              p_kind     = EV_ERROR;
              next_state = S_DISCARD;
              next_cmd_error = 1'b1;
            end
          end
          S_QRY, S_DATA, S_COMMON:
          begin
            push   = 1'b1;
            p_kind = (state == S_COMMON) ? EV_COMMON : EV_DATA;
            if (rx_data == SMP_CH_NL)
            begin
              p_kind     = EV_MSG_END;
              next_state = S_START;
              next_level = 3'h0;
              next_unit_level = 3'h0;
            end
            else if (rx_data == SMP_CH_SEMI)
            begin
              p_kind     = EV_UNIT_END;
              next_state = S_START;
              next_level = unit_level;
            end
            else if (state == S_QRY && rx_data == SMP_CH_SPACE && !term)
            begin
              push       = 1'b0;
              next_state = S_DATA;
            end
            else if (state == S_QRY)
            begin
              p_kind     = EV_ERROR;
              next_state = term ? S_START : S_DISCARD;
              next_cmd_error = 1'b1;
            end
            if (rx_eol)
            begin
              next_state = S_START;
              next_level = 3'h0;
              next_unit_level = 3'h0;
            end
          end
          S_SEP:
          begin
            // Separator or root mark not followed by a keyword
            push           = 1'b1;
            p_kind         = EV_ERROR;
            next_cmd_error = 1'b1;
            next_state     = term ? S_START : S_DISCARD;
            next_level     = term ? 3'h0 : level;
          end
          S_DISCARD:
          begin
            if (term)
            begin
              push       = 1'b1;
              p_kind     = EV_MSG_END;
              next_state = S_START;
              next_level = 3'h0;
              next_unit_level = 3'h0;
            end
          end
          default:
          begin
            next_state = S_START;
            next_level = 3'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= S_START;
      level      <= 3'h0;
      unit_level <= 3'h0;
      kw_buf     <= '0;
      kw_len     <= 4'h0;
      cmd_error  <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      level      <= next_level;
      unit_level <= next_unit_level;
      kw_buf     <= next_kw_buf;
      kw_len     <= next_kw_len;
      cmd_error  <= next_cmd_error;
    end
  end

  // One event at most per character, so the skid can never overflow
  assign p_word = {p_kind, level, p_code, p_char, p_end};

  smp_skid #(.W(SMP_EV_W)) u_skid
  (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (p_word),
    .in_valid  (acc && push),
    .in_ready  (in_ready),
    .out_data  (o_word),
    .out_valid (ev_valid),
    .out_ready (ev_ready)
  );

  assign rx_ready = in_ready;
  assign ev_kind  = smp_ev_e'(o_word[18:16]);
  assign ev_level = o_word[15:13];
  assign ev_code  = o_word[12:9];
  assign ev_char  = o_word[8:1];
  assign ev_end   = o_word[0];

  property p_nl_root;
    @(posedge clk) disable iff (!resetn)
    acc && rx_data == SMP_CH_NL |=> level == 3'h0 && state == S_START;
  endproperty
  a_nl_root : assert property (p_nl_root)
    else $error("Newline did not return parser to root");

  property p_eol_root;
    @(posedge clk) disable iff (!resetn)
    acc && rx_eol |=> level == 3'h0 && state == S_START;
  endproperty
  a_eol_root : assert property (p_eol_root)
    else $error("EOL character did not end the message");

  property p_colon_down;
    @(posedge clk) disable iff (!resetn)
    acc && kw_step && rx_data == SMP_CH_COLON && kw_ok && level != SMP_LVL_MAX
    |=> level == $past(level) + 3'h1 && state == S_SEP;
  endproperty
  a_colon_down : assert property (p_colon_down)
    else $error("Keyword separator did not descend one level");

  property p_query;
    @(posedge clk) disable iff (!resetn)
    acc && kw_step && rx_data == SMP_CH_QUERY && kw_ok
    |-> push && p_kind == EV_QUERY ##1 state == S_QRY;
  endproperty
  a_query : assert property (p_query)
    else $error("Query mark did not produce a query event");

  property p_space_data;
    @(posedge clk) disable iff (!resetn)
    acc && kw_step && rx_data == SMP_CH_SPACE && kw_ok |=> state == S_DATA;
  endproperty
  a_space_data : assert property (p_space_data)
    else $error("Space after keyword did not enter data");

  property p_unit_split;
    @(posedge clk) disable iff (!resetn)
    acc && state == S_DATA && rx_data == SMP_CH_SEMI && !rx_eol
    |=> state == S_START && level == $past(unit_level);
  endproperty
  a_unit_split : assert property (p_unit_split)
    else $error("Semicolon did not start a new unit at the saved level");

  property p_root_mark;
    @(posedge clk) disable iff (!resetn)
    acc && state == S_START && rx_data == SMP_CH_COLON && !rx_eol
    |=> level == 3'h0 && state == S_SEP;
  endproperty
  a_root_mark : assert property (p_root_mark)
    else $error("Root specifier did not reset the tree position");

  property p_sibling;
    @(posedge clk) disable iff (!resetn)
    acc && kw_step && rx_data == SMP_CH_SEMI && kw_ok && !rx_eol
    |=> level == $past(level) && unit_level == $past(level);
  endproperty
  a_sibling : assert property (p_sibling)
    else $error("Unit after semicolon left its sibling level");

  property p_common;
    @(posedge clk) disable iff (!resetn)
    acc && state == S_START && rx_data == SMP_CH_STAR && !rx_eol
    |-> push && p_kind == EV_COMMON ##1 state == S_COMMON;
  endproperty
  a_common : assert property (p_common)
    else $error("Asterisk did not open a common command");

  property p_error_flag;
    @(posedge clk) disable iff (!resetn)
    acc && push && p_kind == EV_ERROR |=> cmd_error ##1 !cmd_error || $past(acc);
  endproperty
  a_error_flag : assert property (p_error_flag)
    else $error("Rejected unit did not raise the command error");

  property p_len_exact;
    @(posedge clk) disable iff (!resetn)
    m_hit |-> m_len <= 4'h9;
  endproperty
  a_len_exact : assert property (p_len_exact)
    else $error("Keyword hit with length beyond any long form");

endmodule : smp_parser

// *** smp_host.sv ***
// Host controller model feeding program message characters
`timescale 1ns/1ps
module smp_host
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       gap,
  input  wire logic       rx_ready,
  output      logic [7:0] rx_data,
  output      logic       rx_eol,
  output      logic       rx_valid
);
  logic [8:0] q[$];
  logic       took = 1'b0;

  function automatic int pending();
    return q.size() + int'(rx_valid);
  endfunction : pending

  function automatic void push(logic [7:0] c, logic e);
    q.push_back({e, c});
  endfunction : push

  initial {rx_valid, rx_eol, rx_data} = 10'h000;
  always @(posedge clk) took <= rx_valid & rx_ready;
  // Held until taken; idle data toggles so a stale byte is never mistaken
  always @(negedge clk or negedge resetn)
    if (!resetn)
      {rx_valid, rx_eol, rx_data} <= 10'h000;
    else if (!rx_valid || took)
    begin
      if (q.size() != 0 && !gap)
      begin
        {rx_eol, rx_data} <= q.pop_front();
        rx_valid <= 1'b1;
      end
      else
      begin
        {rx_valid, rx_eol} <= 2'h0;
        rx_data <= ~rx_data;
      end
    end
endmodule : smp_host

// *** test_scpi_message_parser.sv ***
// Self-checking bench for the program message parser
`timescale 1ns/1ps
module test_scpi_message_parser;
  import smp_pkg::*;
  typedef struct packed
  {
    smp_ev_e    k;
    logic [2:0] l;
    logic [3:0] c;
    logic [7:0] ch;
    logic       e;
  } smp_tev_s;
  logic       clk = 1'b0, resetn = 1'b0, ev_ready = 1'b0, gap = 1'b0, hold = 1'b0;
  logic [7:0] rx_data, ev_char;
  logic       rx_eol, rx_valid, rx_ready, ev_valid, ev_end, cmd_error;
  smp_ev_e    ev_kind;
  logic [2:0] ev_level;
  logic [3:0] ev_code;
  int         mismatches = 0, total_checks = 0, seed = 32'hc69f7979, n_err, errs, tno = 0;
  smp_tev_s   exp_q[$], got_q[$];
  string      sw = "LEVELIMMEDOPERCONDTRIG", dg = "12.5043";
  string      nm[14] = '{"ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE",
                         "OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE",
                         "CURRENT", "FUNCTION"};

  initial forever #50 clk = ~clk;

  smp_host u_smp_host (.clk(clk), .resetn(resetn), .gap(gap), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_eol(rx_eol), .rx_valid(rx_valid));
  smp_parser u_smp_parser (.clk(clk), .resetn(resetn), .rx_data(rx_data), .rx_eol(rx_eol),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .ev_valid(ev_valid), .ev_ready(ev_ready),
    .ev_kind(ev_kind), .ev_level(ev_level), .ev_code(ev_code), .ev_char(ev_char),
    .ev_end(ev_end), .cmd_error(cmd_error));

  always @(posedge clk)
    if (resetn)
    begin
      if (ev_valid && ev_ready)
        got_q.push_back({ev_kind, ev_level, ev_code, ev_char, ev_end});
      if (cmd_error)
        errs++;
    end

  // Consumer stalls at random so the two-entry buffer really fills
  always @(negedge clk)
  begin
    ev_ready <= !hold && ($random(seed) & 3) != 0;
    gap <= ($random(seed) & 3) == 0;
  end

  function automatic int rnd(int n);
    return int'($unsigned($random(seed)) % n);
  endfunction : rnd

  function automatic bit is_al(logic [7:0] c);
    return (c | 8'h20) inside {[8'h61:8'h7a]};
  endfunction : is_al

  function automatic bit is_an(logic [7:0] c);
    return is_al(c) || c inside {[8'h30:8'h39]};
  endfunction : is_an

  function automatic int short_len(int i);
    if (nm[i].len() <= 4)
      return nm[i].len();
    return nm[i][3] inside {"A", "E", "I", "O", "U"} ? 3 : 4;
  endfunction : short_len

  function automatic int kw_code(string w, int lvl);
    string u;
    u = w.toupper();
    if (lvl != 0)
      return (w.len() <= 12) ? 15 : -1;
    for (int i = 0; i < 14; i++)
      if (u == nm[i] || u == nm[i].substr(0, short_len(i) - 1))
        return i;
    return -1;
  endfunction : kw_code

  function automatic void add(smp_ev_e k, int l, int c, logic [7:0] ch, logic e);
    exp_q.push_back({k, 3'(l), 4'(c), ch, e});
    if (k == EV_ERROR)
      n_err++;
  endfunction : add

  function automatic void ref_model(string s, bit eol);
    int         st, lvl, ks, cd;
    bit         sep, t;
    logic [7:0] c;
    smp_ev_e    k;
    {st, lvl, ks, sep, n_err} = '0;
    for (int i = 0; i < s.len(); i++)
    begin
      c = s[i];
      t = c == SMP_CH_NL || (eol && i == s.len() - 1);
      if (st == 0 && is_al(c))
      begin
        {ks, st, sep} = {i, 1, 1'b0};
      end
      case (st)
        0:
          if (c == SMP_CH_COLON && !sep)
            {lvl, sep} = {0, 1'b1};
          else if (c == SMP_CH_STAR && !sep)
          begin
            add(EV_COMMON, 0, 0, c, 0);
            st = 4;
          end
          else if (c != SMP_CH_SPACE || sep)
          begin
            add(EV_ERROR, 0, 0, c, 0);
            st = 5;
          end
        1:
          if (!is_an(c) || t)
          begin
            cd = kw_code(s.substr(ks, is_an(c) ? i : i - 1), lvl);
            k = c == SMP_CH_COLON ? EV_KW : c == SMP_CH_QUERY ? EV_QUERY : EV_SET;
            if (cd < 0 || !(t || c inside {SMP_CH_COLON, SMP_CH_QUERY, SMP_CH_SPACE, SMP_CH_SEMI}))
            begin
              add(EV_ERROR, 0, 0, c, 0);
              st = 5;
            end
            else
            begin
              add(k, lvl, cd, c, t);
              lvl += int'(k == EV_KW);
              sep = k == EV_KW;
              st = k == EV_QUERY ? 2 : c == SMP_CH_SPACE ? 3 : 0;
            end
          end
        default:
          if (c == SMP_CH_SEMI && st != 5)
          begin
            add(EV_UNIT_END, 0, 0, c, 0);
            st = 0;
          end
          else if (c == SMP_CH_NL || (t && st == 5))
            add(EV_MSG_END, 0, 0, c, 1);
          else if (st == 2 && c == SMP_CH_SPACE)
            st = 3;
          else if (st == 2)
          begin
            add(EV_ERROR, 0, 0, c, 0);
            st = 5;
          end
          else if (st != 5)
            add(st == 3 ? EV_DATA : EV_COMMON, 0, 0, c, t);
      endcase
      if (t)
        {st, lvl, sep} = '0;
    end
  endfunction : ref_model

  function automatic string rand_msg();
    string m, w;
    int    id;
    m = "";
    for (int u = 0; u <= rnd(3); u++)
    begin
      id = rnd(14);
      if (u > 0)
        m = {m, rnd(2) ? ";" : ";:"};
      w = nm[id].substr(0, (rnd(2) ? nm[id].len() : short_len(id)) - 1);
      if (nm[id].len() > 5 && rnd(6) == 0)
        w = {nm[id].substr(0, short_len(id)), "?"};
      for (int j = 0; j < w.len(); j++)
        if (rnd(2))
          w[j] = w[j] | 8'h20;
      m = {m, w};
      repeat (rnd(3))
      begin
        id = rnd(18);
        m = {m, ":", sw.substr(id, id + 2 + rnd(3))};
      end
      id = rnd(4);
      case (rnd(4))
        1: m = {m, "?"};
        2: m = {m, " ", dg.substr(id, id + rnd(3))};
        3: m = {m, "? 7"};
        default: ;
      endcase
    end
    return {m, "\n"};
  endfunction : rand_msg

  task automatic cmp_ev(smp_tev_s g, smp_tev_s x);
    bit kw;
    kw = x.k inside {EV_KW, EV_SET, EV_QUERY};
    total_checks++;
    if (g.k !== x.k || (x.k != EV_ERROR && {g.ch, g.e} !== {x.ch, x.e})
        || (kw && {g.l, g.c} !== {x.l, x.c}))
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t test %0d event %h expected %h", $time, tno, g, x);
    end
  endtask : cmp_ev

  task automatic cmp_val(logic [31:0] g, logic [31:0] x, string what);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t test %0d %s got %h expected %h", $time, tno, what, g, x);
    end
  endtask : cmp_val

  task automatic run_msg(string s, bit eol = 0);
    int n;
    {n, errs} = '0;
    exp_q.delete();
    got_q.delete();
    ref_model(s, eol);
    tno++;
    for (int i = 0; i < s.len(); i++)
      u_smp_host.push(s[i], eol && i == s.len() - 1);
    if (hold)
    begin
      repeat (s.len() + 8) @(negedge clk);
      cmp_val(rx_ready, 0, "ready while full");
      cmp_val({ev_valid, ev_kind, ev_char}, {1'b1, EV_COMMON, SMP_CH_STAR}, "oldest held");
      hold = 1'b0;
    end
    while ((u_smp_host.pending() != 0 || got_q.size() < exp_q.size()) && n++ < 4000)
      @(negedge clk);
    repeat (6) @(negedge clk);
    cmp_val(got_q.size(), exp_q.size(), "event count");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      cmp_ev(got_q[i], exp_q[i]);
    cmp_val(errs, n_err, "error pulses");
    $display("test %0d done", tno);
  endtask : run_msg

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial
  begin
    #3000000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(negedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    cmp_val({rx_ready, ev_valid, cmd_error}, 3'h4, "after reset");
    run_msg("VOLT 5\n");
    run_msg("voltage:LeV:imm 16\n");
    run_msg("STAT:OPER:COND?; ENAB 16\n");
    run_msg("meas:volt?;:curr?\n");
    run_msg(":INIT ON;:TRIG;:MEAS:CURR?;VOLT?\n");
    run_msg("LIST?;:CAL?;:FUNC 2\n");
    run_msg("LIS?\n");
    run_msg("CALI?\n");
    run_msg("OUTPU 1\n");
    run_msg("MEM?\n");
    run_msg("VOLT 5\r\n");
    run_msg("TRIG", 1);
    run_msg("VOLT 3", 1);
    run_msg("OUTP?\n");
    hold = 1'b1;
    run_msg("*RST;*CLS\n");
    for (int i = 0; i < 14; i++)
    begin
      run_msg({nm[i], "?\n"});
      run_msg({nm[i].substr(0, short_len(i) - 1), "?\n"});
    end
    repeat (40)
    begin
      @(posedge clk);
      run_msg(rand_msg());
    end
    stop_test();
  end
endmodule : test_scpi_message_parser
